//--- shared/sfsw_pkg.sv
// Shared constants and carriers for the serial flash status-write and read sequencer.
// Assumes a 250 MHz system clock that samples the serial pins.
`default_nettype none
package sfsw_pkg;
  // Opcodes.
  localparam logic [7:0] SFSW_OP_MONITOR = 8'h25;
  localparam logic [7:0] SFSW_OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] SFSW_OP_CONFIG_WRITE = 8'h31;
  localparam logic [7:0] SFSW_OP_READ = 8'h03;
  localparam logic [7:0] SFSW_OP_FAST_READ = 8'h0b;
  localparam logic [7:0] SFSW_OP_DUAL_READ = 8'h3b;
  // Status register bit positions.
  localparam int SFSW_BIT_WIP = 0;
  localparam int SFSW_BIT_WEL = 1;
  localparam int SFSW_BIT_SRP_LO = 7;
  localparam int SFSW_BIT_SRP_HI = 8;
  localparam int SFSW_BIT_QE = 9;
  localparam int SFSW_BIT_CMP = 14;
  // Bits a status write never alters (S15, S10, S1, S0).
  localparam logic [15:0] SFSW_SR_KEEP_MASK = 16'h8403;
  // Bits cleared by a one-byte status write (complement, quad enable, protect hi).
  localparam logic [15:0] SFSW_SR_ONE_BYTE_CLR = 16'h4300;
  // Values after reset.
  localparam logic [15:0] SFSW_SR_RESET = 16'h0000;
  localparam logic [7:0] SFSW_CR_RESET = 8'h00;
  // Clock rate and self-timed write length.
  localparam int SFSW_CLK_MHZ = 250;
  localparam int SFSW_WRITE_TIME_US = 5;
  localparam int SFSW_WRITE_CYCLES = SFSW_WRITE_TIME_US * SFSW_CLK_MHZ;
  // Field sizes in serial clocks.
  localparam int SFSW_ADDR_BITS = 24;
  localparam int SFSW_DUMMY_CLKS = 8;
  // Command phases, one-hot.
  typedef enum logic [5:0] {
    SFSW_ST_OPCODE = 6'b00_0001,
    SFSW_ST_ADDR = 6'b00_0010,
    SFSW_ST_DUMMY = 6'b00_0100,
    SFSW_ST_DATA_OUT = 6'b00_1000,
    SFSW_ST_DATA_IN = 6'b01_0000,
    SFSW_ST_IGNORE = 6'b10_0000
  } sfsw_phase_e;
  // Pin outputs as a group.
  typedef struct packed {
    logic io0_o;
    logic io0_oe_n;
    logic io1_o;
    logic io1_oe_n;
  } sfsw_pins_s;
endpackage : sfsw_pkg
`default_nettype wire

//--- design/sfsw_array.sv
// Flash array read port: a registered-output memory.
// Assumes one read per clock on the system clock; contents start as an address pattern.
`timescale 1ns/100ps
`default_nettype none
module sfsw_array #(
  parameter int AW = 8
) (
  // Clock.
  input wire logic clock,
  // Read port.
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  import sfsw_pkg::*;
  // Storage; each byte starts out holding the low bits of its own address.
  logic [7:0] mem [0:(1<<AW)-1];
  // Initial contents: address pattern so reads are visible.
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = i[7:0];
    end
  end
  // Read data comes out of a register.
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule : sfsw_array
`default_nettype wire

//--- design/sfsw_seq.sv
// Command sequencer of a serial NOR flash: monitor, status/config writes, reads.
// Assumes serial pins are asynchronous to clock; serial clock well below clock/4.
`timescale 1ns/100ps
`default_nettype none
module sfsw_seq
  import sfsw_pkg::*;
#(
  parameter int AW = 8,
  parameter int WRITE_CYCLES = sfsw_pkg::SFSW_WRITE_CYCLES
) (
  // System clock and synchronous active-low reset.
  input wire logic clock,
  input wire logic rstn,
  // Serial link pins from the host.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic io0_i,
  input wire logic wp_n,
  // Serial link pin drive.
  output sfsw_pkg::sfsw_pins_s pins,
  // Side inputs from the rest of the device.
  input wire logic latch_set_cmd,
  input wire logic array_busy,
  // Visible state.
  output logic [15:0] status_reg,
  output logic [7:0] config_reg
);
  import sfsw_pkg::*;

  // Whole module state.
  typedef struct packed {
    logic [1:0] cs_sy;
    logic [1:0] ck_sy;
    logic [1:0] di_sy;
    logic [1:0] wp_sy;
    logic ck_prev;
    logic cs_prev;
    sfsw_phase_e phase;
    logic [7:0] opcode;
    logic [5:0] bitcnt;
    logic [23:0] addr;
    logic [15:0] shin;
    logic [4:0] datcnt;
    logic [7:0] shout;
    logic [2:0] outcnt;
    logic monitor;
    logic [15:0] sr;
    logic [7:0] cr;
    logic write_enable_latch;
    logic [31:0] timer;
    logic busy;
    sfsw_pins_s pins;
  } sfsw_state_s;

  sfsw_state_s st_r;
  sfsw_state_s st_nxt;
  logic [7:0] rd_data;

  // Array read port; the address leads the byte being loaded.
  sfsw_array #(.AW(AW)) u_array (
    .clock(clock),
    .rd_addr(st_r.addr[AW-1:0]),
    .rd_data(rd_data)
  );

  // Hardware protection test on the protect bits and write-protect pin.
  function automatic logic hw_locked(input logic [15:0] sr, input logic wp);
    hw_locked = (!sr[SFSW_BIT_SRP_HI] && sr[SFSW_BIT_SRP_LO] && !wp)
      || sr[SFSW_BIT_SRP_HI];
  endfunction : hw_locked

  // Next-state logic.
  always_comb begin
    logic cs_low;
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] op;
    logic [15:0] newsr;
    cs_low = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    cs_rise = 1'b0;
    cs_fall = 1'b0;
    op = 8'h00;
    newsr = 16'h0000;
    st_nxt = st_r;
    // Two-flop synchronisers; only the second stage is read.
    st_nxt.cs_sy = {st_r.cs_sy[0], cs_n};
    st_nxt.ck_sy = {st_r.ck_sy[0], sclk};
    st_nxt.di_sy = {st_r.di_sy[0], io0_i};
    st_nxt.wp_sy = {st_r.wp_sy[0], wp_n};
    st_nxt.ck_prev = st_r.ck_sy[1];
    st_nxt.cs_prev = st_r.cs_sy[1];
    cs_low = !st_r.cs_sy[1];
    rise = cs_low && st_r.ck_sy[1] && !st_r.ck_prev;
    fall = cs_low && !st_r.ck_sy[1] && st_r.ck_prev;
    cs_rise = st_r.cs_sy[1] && !st_r.cs_prev;
    cs_fall = !st_r.cs_sy[1] && st_r.cs_prev;
    // Latch set from the write-enable command handler.
    if (latch_set_cmd && !st_r.busy) begin
      st_nxt.write_enable_latch = 1'b1;
    end
    // Self-timed write cycle countdown.
    if (st_r.busy) begin
      if (st_r.timer <= 32'd1) begin
        st_nxt.busy = 1'b0;
        st_nxt.write_enable_latch = 1'b0;
        st_nxt.timer = 32'd0;
      end else begin
        st_nxt.timer = st_r.timer - 32'd1;
      end
    end
    // Frame start resets the command decoder.
    if (cs_fall) begin
      st_nxt.phase = SFSW_ST_OPCODE;
      st_nxt.bitcnt = 6'd0;
      st_nxt.datcnt = 5'd0;
      st_nxt.monitor = 1'b0;
    end
    // Rising serial clock: sample input, most significant bit first.
    if (rise) begin
      unique case (st_r.phase)
        SFSW_ST_OPCODE: begin
          op = {st_r.opcode[6:0], st_r.di_sy[1]};
          st_nxt.opcode = op;
          st_nxt.bitcnt = st_r.bitcnt + 6'd1;
          if (st_r.bitcnt == 6'd7) begin
            st_nxt.bitcnt = 6'd0;
            if (op == SFSW_OP_MONITOR) begin
              st_nxt.monitor = 1'b1;
              st_nxt.phase = SFSW_ST_IGNORE;
            end else if (op == SFSW_OP_STATUS_WRITE || op == SFSW_OP_CONFIG_WRITE) begin
              st_nxt.phase = SFSW_ST_DATA_IN;
            end else if (op == SFSW_OP_READ) begin
              st_nxt.phase = SFSW_ST_ADDR;
            end else if ((op == SFSW_OP_FAST_READ || op == SFSW_OP_DUAL_READ)
                         && !(st_r.busy || array_busy)) begin
              st_nxt.phase = SFSW_ST_ADDR;
            end else begin
              st_nxt.phase = SFSW_ST_IGNORE;
            end
          end
        end
        SFSW_ST_ADDR: begin
          st_nxt.addr = {st_r.addr[22:0], st_r.di_sy[1]};
          st_nxt.bitcnt = st_r.bitcnt + 6'd1;
          if (st_r.bitcnt == 6'(SFSW_ADDR_BITS - 1)) begin
            st_nxt.bitcnt = 6'd0;
            st_nxt.phase = (st_r.opcode == SFSW_OP_READ) ? SFSW_ST_DATA_OUT
                                                         : SFSW_ST_DUMMY;
          end
        end
        SFSW_ST_DUMMY: begin
          st_nxt.bitcnt = st_r.bitcnt + 6'd1;
          if (st_r.bitcnt == 6'(SFSW_DUMMY_CLKS - 1)) begin
            st_nxt.bitcnt = 6'd0;
            st_nxt.phase = SFSW_ST_DATA_OUT;
          end
        end
        SFSW_ST_DATA_IN: begin
          st_nxt.shin = {st_r.shin[14:0], st_r.di_sy[1]};
          if (st_r.datcnt != 5'd31) begin
            st_nxt.datcnt = st_r.datcnt + 5'd1;
          end
        end
        SFSW_ST_DATA_OUT: begin
        end
        SFSW_ST_IGNORE: begin
        end
      endcase
    end
    // Falling serial clock: launch output bits.
    if (fall && st_r.phase == SFSW_ST_DATA_OUT) begin
      if (st_r.outcnt == 3'd0) begin
        // New byte from the array; bump address for the next byte.
        st_nxt.shout = rd_data;
        st_nxt.addr = st_r.addr + 24'd1;
      end
      if (st_r.opcode == SFSW_OP_DUAL_READ) begin
        st_nxt.pins.io1_oe_n = 1'b0;
        st_nxt.pins.io0_oe_n = 1'b0;
        if (st_r.outcnt == 3'd0) begin
          st_nxt.pins.io1_o = rd_data[7];
          st_nxt.pins.io0_o = rd_data[6];
          st_nxt.shout = {rd_data[5:0], 2'b00};
        end else begin
          st_nxt.pins.io1_o = st_r.shout[7];
          st_nxt.pins.io0_o = st_r.shout[6];
          st_nxt.shout = {st_r.shout[5:0], 2'b00};
        end
        st_nxt.outcnt = (st_r.outcnt == 3'd3) ? 3'd0 : st_r.outcnt + 3'd1;
      end else begin
        st_nxt.pins.io1_oe_n = 1'b0;
        if (st_r.outcnt == 3'd0) begin
          st_nxt.pins.io1_o = rd_data[7];
          st_nxt.shout = {rd_data[6:0], 1'b0};
        end else begin
          st_nxt.pins.io1_o = st_r.shout[7];
          st_nxt.shout = {st_r.shout[6:0], 1'b0};
        end
        st_nxt.outcnt = st_r.outcnt + 3'd1;
      end
    end
    // Busy level monitor drives the write-cycle busy flag ORed with array_busy, clock-free.
    if (st_r.monitor && cs_low) begin
      st_nxt.pins.io1_oe_n = 1'b0;
      st_nxt.pins.io1_o = st_r.busy || array_busy;
    end
    // Frame end: float outputs and commit any write.
    if (cs_rise) begin
      st_nxt.pins.io1_oe_n = 1'b1;
      st_nxt.pins.io0_oe_n = 1'b1;
      st_nxt.monitor = 1'b0;
      st_nxt.outcnt = 3'd0;
      st_nxt.phase = SFSW_ST_IGNORE;
      if (st_r.phase == SFSW_ST_DATA_IN && st_r.write_enable_latch && !st_r.busy) begin
        if (st_r.opcode == SFSW_OP_STATUS_WRITE
            && !hw_locked(st_r.sr, st_r.wp_sy[1])) begin
          if (st_r.datcnt == 5'd8) begin
            newsr = {st_r.sr[15:8], st_r.shin[7:0]} & ~SFSW_SR_ONE_BYTE_CLR;
          end else begin
            newsr = {st_r.shin[7:0], st_r.shin[15:8]};
          end
          if (st_r.datcnt == 5'd8 || st_r.datcnt == 5'd16) begin
            st_nxt.sr = (newsr & ~SFSW_SR_KEEP_MASK) | (st_r.sr & SFSW_SR_KEEP_MASK);
            st_nxt.busy = 1'b1;
            st_nxt.timer = 32'(WRITE_CYCLES);
          end
        end else if (st_r.opcode == SFSW_OP_CONFIG_WRITE && st_r.datcnt == 5'd8) begin
          st_nxt.cr = st_r.shin[7:0];
          st_nxt.busy = 1'b1;
          st_nxt.timer = 32'(WRITE_CYCLES);
        end
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_r <= '{cs_sy: 2'b11, ck_sy: 2'b11, di_sy: 2'b00, wp_sy: 2'b11,
                ck_prev: 1'b1, cs_prev: 1'b1, phase: SFSW_ST_IGNORE,
                opcode: 8'h00, bitcnt: 6'd0, addr: 24'h00_0000, shin: 16'h0000,
                datcnt: 5'd0, shout: 8'h00, outcnt: 3'd0, monitor: 1'b0,
                sr: SFSW_SR_RESET, cr: SFSW_CR_RESET, write_enable_latch: 1'b0,
                timer: 32'd0, busy: 1'b0,
                pins: '{io0_o: 1'b0, io0_oe_n: 1'b1, io1_o: 1'b0, io1_oe_n: 1'b1}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register; status always readable.
  assign pins = st_r.pins;
  assign status_reg = {st_r.sr[15:2], st_r.write_enable_latch, st_r.busy};
  assign config_reg = st_r.cr;
endmodule : sfsw_seq
`default_nettype wire

//--- testbench/sfsw_seq_sva.sv
// Checker of the flash command sequencer, bound to the ports of sfsw_seq.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sfsw_chk
  import sfsw_pkg::*;
#(
  parameter int WRITE_CYCLES = sfsw_pkg::SFSW_WRITE_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Serial pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic io0_i,
  input wire logic wp_n,
  input wire sfsw_pkg::sfsw_pins_s pins,
  // Side inputs and visible state.
  input wire logic latch_set_cmd,
  input wire logic array_busy,
  input wire logic [15:0] status_reg,
  input wire logic [7:0] config_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Counts how long the busy flag has stood, so its length can be judged at the fall.
  logic [15:0] busy_cnt_r;
  always_ff @(posedge clock) begin
    busy_cnt_r <= (!rstn || !status_reg[0]) ? 16'h0000 : busy_cnt_r + 16'h0001;
  end
  float_idle_a: assert property (cs_n [*6] |-> pins.io1_oe_n && pins.io0_oe_n)
    else $error("output driven while deselected");
  drive_frame_a: assert property (!pins.io1_oe_n |-> !$past(cs_n, 5))
    else $error("output driven outside a frame");
  io0_pair_a: assert property (!pins.io0_oe_n |-> !pins.io1_oe_n)
    else $error("second data line driven alone");
  wel_clear_a: assert property ($fell(status_reg[0]) |-> !status_reg[1])
    else $error("latch kept after write cycle");
  keep_bits_a: assert property (!$stable(status_reg[15:2]) |->
    $stable(status_reg[15]) && $stable(status_reg[10]))
    else $error("fixed status bit changed");
  busy_len_a: assert property ($fell(status_reg[0]) && !$past(array_busy, 4) |->
    busy_cnt_r >= WRITE_CYCLES - 1 && busy_cnt_r <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  latch_set_a: assert property (latch_set_cmd && !status_reg[0] |-> ##[1:3] status_reg[1])
    else $error("latch not set");
  need_latch_a: assert property (!$stable(status_reg[15:2]) |-> $past(status_reg[1]))
    else $error("status written without latch");
  cfg_latch_a: assert property (!$stable(config_reg) |-> $past(status_reg[1]))
    else $error("config written without latch");
  refuse_read_a: assert property (array_busy [*8] |-> pins.io0_oe_n)
    else $error("dual read answered while busy");
endmodule : sfsw_chk
`default_nettype wire

//--- testbench/sfsw_host.sv
// Host serial controller model in mode 0: the clock idles low between frames.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
`default_nettype none
module sfsw_host (
  // Host drive.
  output var logic cs_n,
  output var logic sclk,
  output var logic mosi,
  // Device answer lines.
  input wire logic so,
  input wire logic io0
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Shifts n bits out, most significant first; mode 0 needs no trailing monitor bit.
  task automatic put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      mosi = v[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    mosi = ~mosi;
  endtask : put
  // Samples n clocks of answer just before each rising edge.
  task automatic get(input int n, input logic dual, output logic [7:0] d);
    d = 8'h00;
    for (int i = 0; i < n; i++) begin
      #62.5 d = dual ? {d[5:0], so, io0} : {d[6:0], so};
      sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
  endtask : get
  task automatic open_frame();
    #62.5 cs_n = 1'b0;
  endtask : open_frame
  task automatic close_frame();
    #62.5 cs_n = 1'b1;
    #62.5;
  endtask : close_frame
endmodule : sfsw_host
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the flash command sequencer driven by the host model.
// Assumes sfsw_host and the checker sfsw_chk are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sfsw_pkg::*;
  localparam int WC = 600;
  logic clock, rstn, latch_set_cmd, array_busy, wp_n, cs_n, sclk, io0_i;
  logic so_w, io0_w, so_q, io0_q;
  logic [15:0] status_reg;
  logic [7:0] config_reg, d;
  sfsw_pins_s pins;
  int failures, n_compared;
  sfsw_seq #(.AW(8), .WRITE_CYCLES(WC)) uut (.clock(clock), .rstn(rstn), .cs_n(cs_n),
    .sclk(sclk), .io0_i(io0_i), .wp_n(wp_n), .pins(pins), .latch_set_cmd(latch_set_cmd),
    .array_busy(array_busy), .status_reg(status_reg), .config_reg(config_reg));
  sfsw_host host (.cs_n(cs_n), .sclk(sclk), .mosi(io0_i), .so(so_w), .io0(io0_w));
  // A released line shows the inverse of what was last driven, so a stale value can never pass.
  assign so_w = pins.io1_oe_n ? ~so_q : pins.io1_o;
  assign io0_w = pins.io0_oe_n ? ~io0_q : pins.io0_o;
  // Remembers the last driven level of each answer line; one driver per variable.
  always @(posedge clock) begin
    if (!rstn) begin
      so_q <= 1'b0;
      io0_q <= 1'b0;
    end else begin
      if (!pins.io1_oe_n) begin
        so_q <= pins.io1_o;
      end
      if (!pins.io0_oe_n) begin
        io0_q <= pins.io0_o;
      end
    end
  end
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1.3;
  endtask : tick
  task automatic latch();
    tick(1);
    latch_set_cmd = 1'b1;
    tick(1);
    latch_set_cmd = 1'b0;
  endtask : latch
  // Sends one command frame with an optional data field.
  task automatic frame(input logic [7:0] op, input logic [31:0] v, input int n);
    host.open_frame();
    host.put({24'h0, op}, 8);
    if (n > 0) host.put(v, n);
    host.close_frame();
  endtask : frame
  // Waits, bounded, for the self-timed cycle to end.
  task automatic wait_done();
    tick(8);
    check("busy", status_reg[0], 1'b1);
    for (int k = 0; k < WC + 50 && status_reg[0] !== 1'b0; k++) tick(1);
    check("busy end", status_reg[0], 1'b0);
  endtask : wait_done
  // Reads n bytes; the array holds its own address, wrapping at 256.
  task automatic rd(input logic [7:0] op, input logic [7:0] a, input int dum,
    input logic dual, input int n);
    host.open_frame();
    host.put({24'h0, op}, 8);
    host.put({24'h0, a}, 24);
    if (dum > 0) host.put(32'h0, dum);
    for (int i = 0; i < n; i++) begin
      host.get(dual ? 4 : 8, dual, d);
      check("read byte", d, 8'(a + 8'(i)));
    end
    host.close_frame();
  endtask : rd
  task automatic t_reads();
    rd(SFSW_OP_READ, 8'hfe, 0, 1'b0, 3);
    rd(SFSW_OP_FAST_READ, 8'h10, 8, 1'b0, 2);
    rd(SFSW_OP_DUAL_READ, 8'h20, 8, 1'b1, 2);
  endtask : t_reads
  // Sends a fast or dual read that must be refused; both answer lines must stay released.
  task automatic refused(input logic [7:0] op);
    host.open_frame();
    host.put({24'h0, op}, 8);
    host.put(32'h0, 32);
    host.get(8, 1'b0, d);
    check("refused float", {pins.io1_oe_n, pins.io0_oe_n}, 2'b11);
    host.close_frame();
  endtask : refused
  task automatic t_refused();
    tick(1);
    array_busy = 1'b1;
    refused(SFSW_OP_FAST_READ);
    refused(SFSW_OP_DUAL_READ);
    tick(1);
    array_busy = 1'b0;
  endtask : t_refused
  task automatic t_status();
    frame(SFSW_OP_STATUS_WRITE, 32'h00ff, 16);
    tick(10);
    check("no latch", status_reg, 16'h0000);
    latch();
    frame(SFSW_OP_STATUS_WRITE, 32'h7fc6, 16);
    tick(8);
    check("busy", status_reg[0], 1'b1);
    host.open_frame();
    host.put({24'h0, SFSW_OP_MONITOR}, 8);
    tick(20);
    check("monitor busy", so_w, 1'b1);
    for (int k = 0; k < WC && so_w !== 1'b0; k++) tick(1);
    tick(4);
    check("monitor ready", {so_w, status_reg}, {1'b0, 16'h427c});
    host.close_frame();
    tick(4);
    check("monitor float", pins.io1_oe_n, 1'b1);
    latch();
    frame(SFSW_OP_STATUS_WRITE, 32'h04, 8);
    wait_done();
    check("one byte", status_reg, 16'h0004);
  endtask : t_status
  task automatic t_config();
    latch();
    frame(SFSW_OP_STATUS_WRITE, 32'hfff, 12);
    frame(SFSW_OP_CONFIG_WRITE, 32'h14b, 9);
    tick(10);
    check("bad length", {config_reg, status_reg}, {8'h00, 16'h0006});
    frame(SFSW_OP_CONFIG_WRITE, 32'ha5, 8);
    tick(8);
    check("busy", status_reg[0], 1'b1);
    // A dual read during the self-timed cycle is refused and the cycle still completes.
    refused(SFSW_OP_DUAL_READ);
    check("config", {config_reg, status_reg}, {8'ha5, 16'h0004});
  endtask : t_config
  task automatic t_protect();
    latch();
    frame(SFSW_OP_STATUS_WRITE, 32'h84, 8);
    wait_done();
    wp_n = 1'b0;
    latch();
    frame(SFSW_OP_STATUS_WRITE, 32'h04, 8);
    tick(10);
    check("locked", status_reg, 16'h0086);
    wp_n = 1'b1;
    frame(SFSW_OP_STATUS_WRITE, 32'h04, 8);
    wait_done();
    check("unlocked", status_reg, 16'h0004);
  endtask : t_protect
  initial begin
    {rstn, latch_set_cmd, array_busy} = '0;
    wp_n = 1'b1;
    failures = 0;
    n_compared = 0;
    tick(4);
    rstn = 1'b1;
    tick(4);
    check("reset", {pins.io1_oe_n, pins.io0_oe_n, config_reg, status_reg}, {2'b11, 24'h0});
    t_reads();
    t_refused();
    t_status();
    t_config();
    t_protect();
    end_of_test();
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    #300000;
    failures++;
    end_of_test();
  end
endmodule : tb_top
bind sfsw_seq sfsw_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clock(clock), .rstn(rstn),
  .cs_n(cs_n), .sclk(sclk), .io0_i(io0_i), .wp_n(wp_n), .pins(pins),
  .latch_set_cmd(latch_set_cmd), .array_busy(array_busy), .status_reg(status_reg),
  .config_reg(config_reg));
`default_nettype wire
